// File: rtl/drc_ladder.sv
// Purpose: digital model of the resistor ladder tap select
// Assumes: one-hot tap select drives the analog ladder switches
// Notes: disabled converter opens all taps
`default_nettype none
module drc_ladder #(
   parameter int LEVEL_W = 5
) (
   input wire logic enable_i,
   input wire logic [LEVEL_W-1:0] code_i,
   output logic [(1<<LEVEL_W)-1:0] tap_o
);
   // Tap vector grows as a power of two; refuse sizes it cannot serve
   if (LEVEL_W < 1 || LEVEL_W > 8) begin : g_bad_width
      $error("drc_ladder: LEVEL_W out of range");
   end

   // Tap index equals code: 0 lowest, all ones highest, monotonic
   for (genvar i = 0; i < (1 << LEVEL_W); i++) begin : g_tap
      assign tap_o[i] = enable_i &
         (code_i == LEVEL_W'(i)); // [R5] [R6]
   end
endmodule
`default_nettype wire

// File: rtl/drc_pkg.sv
// Purpose: constants and types for the DAC reference control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: register offsets are local choices
// Summary of operation
// [R1] The pin output enable bit routes the DAC level to the output pin.
// [R2] The pin is driven only when the fixed-reference gate also allows it.
// [R3] Upper source select 0 picks the supply rail, 1 the external pin.
// [R4] The level register holds a 5-bit code in bits 4..0, upper bits zero.
// [R5] Code all ones selects the highest output step.
// [R6] Code all zeros selects the lowest step, rising monotonically between.
// [R7] Every writable bit of both registers resets to zero on any reset.
// [R8] Bit 7 enables the converter, bit 6 selects full range, rest read 0; here bits 5 (pin enable) and 2 (source select) also store and read back.
`default_nettype none
package drc_pkg;
   localparam logic [11:0] CFG_OFFSET = 12'h000;
   localparam logic [11:0] LVL_OFFSET = 12'h004;
   localparam int ON_BIT = 7;
   localparam int RANGE_BIT = 6;
   localparam int PIN_BIT = 5;
   localparam int SRC_BIT = 2;
   localparam int LEVEL_W = 5;
   localparam logic [7:0] CFG_MASK = 8'he4;
   localparam logic [7:0] LVL_MASK = 8'h1f;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] LVL_RESET = 8'h00;
   localparam logic SRC_SUPPLY = 1'b0;
   localparam logic SRC_EXTPIN = 1'b1;

   // Settings handed to the analog side
   typedef struct packed {
      logic converter_on;
      logic range_select;
      logic pin_output_on;
      logic upper_source_select;
      logic [LEVEL_W-1:0] level_code;
   } drc_ctrl_t;
endpackage
`default_nettype wire

// File: rtl/drc_regs.sv
// Purpose: APB register file for the two DAC control registers
// Assumes: single clock, synchronous active-low reset
// Notes: zero wait states, unmapped addresses read zero with pslverr
`default_nettype none
module drc_regs (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic [7:0] cfg_o,
   output logic [7:0] lvl_o
);
   logic [7:0] cfg_ff;
   logic [7:0] lvl_ff;
   logic hit_cfg;
   logic hit_lvl;
   logic wr_en;

   assign hit_cfg = (paddr_i == drc_pkg::CFG_OFFSET);
   assign hit_lvl = (paddr_i == drc_pkg::LVL_OFFSET);
   // Low lane only carries data; other lanes ignored
   assign wr_en = psel_i & penable_i & pwrite_i & pstrb_i[0];

   // Unimplemented bits masked so they never store
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cfg_ff <= drc_pkg::CFG_RESET; // [R7]
         lvl_ff <= drc_pkg::LVL_RESET; // [R7]
      end else if (wr_en) begin
         if (hit_cfg) begin
            cfg_ff <= pwdata_i[7:0] & drc_pkg::CFG_MASK; // [R8]
         end
         if (hit_lvl) begin
            lvl_ff <= pwdata_i[7:0] & drc_pkg::LVL_MASK; // [R4]
         end
      end
   end

   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~(hit_cfg | hit_lvl);
   // Read mux; upper bits and reserved bits read zero
   always_comb begin
      prdata_o = 32'h0000_0000;
      if (hit_cfg) begin
         prdata_o = {24'h00_0000, cfg_ff};
      end else if (hit_lvl) begin
         prdata_o = {24'h00_0000, lvl_ff};
      end
   end

   assign cfg_o = cfg_ff;
   assign lvl_o = lvl_ff;
endmodule
`default_nettype wire

// File: rtl/drc_top.sv
// Purpose: DAC reference control, APB registers to analog controls
// Assumes: fixed-reference gate arrives from another clock domain or pin
// Notes: all outputs registered; one cycle after register update
//
// Design decisions made here: the APB register port and the placing of the registers.
`default_nettype none
module drc_top (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic fixed_ref_gate_i,
   output drc_pkg::drc_ctrl_t ctrl_o,
   output logic [31:0] tap_o,
   output logic analog_out_pin_o,
   output logic src_supply_o,
   output logic src_extpin_o
);
   logic [7:0] cfg;
   logic [7:0] lvl;
   logic [31:0] prdata;
   logic [31:0] tap;
   logic hit_any;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic gate_meta_ff;
   logic gate_sync_ff;
   drc_pkg::drc_ctrl_t ctrl_ff;
   drc_pkg::drc_ctrl_t nxt_ctrl;
   logic [31:0] tap_ff;
   logic pin_ff;
   logic src_supply_ff;
   logic src_extpin_ff;

   drc_regs u_regs (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i),
      .prdata_o(prdata),
      .pready_o(),
      .pslverr_o(),
      .cfg_o(cfg),
      .lvl_o(lvl)
   );

   assign hit_any = (paddr_i == drc_pkg::CFG_OFFSET) |
      (paddr_i == drc_pkg::LVL_OFFSET);

   // Answer latched in the setup cycle, so the access still has no wait
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= psel_i & ~penable_i;
         pslverr_ff <= psel_i & ~penable_i & ~hit_any;
         if (psel_i & ~penable_i) begin
            prdata_ff <= prdata;
         end
      end
   end

   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;

   // Gate comes from outside the clock domain
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         gate_meta_ff <= 1'b0;
         gate_sync_ff <= 1'b0;
      end else begin
         gate_meta_ff <= fixed_ref_gate_i;
         gate_sync_ff <= gate_meta_ff;
      end
   end

   // Field unpacking
   always_comb begin
      nxt_ctrl.converter_on = cfg[drc_pkg::ON_BIT]; // [R8]
      nxt_ctrl.range_select = cfg[drc_pkg::RANGE_BIT]; // [R8]
      nxt_ctrl.pin_output_on = cfg[drc_pkg::PIN_BIT];
      nxt_ctrl.upper_source_select = cfg[drc_pkg::SRC_BIT];
      nxt_ctrl.level_code = lvl[drc_pkg::LEVEL_W-1:0]; // [R4]
   end

   drc_ladder #(
      .LEVEL_W(drc_pkg::LEVEL_W)
   ) u_ladder (
      .enable_i(cfg[drc_pkg::ON_BIT]),
      .code_i(lvl[drc_pkg::LEVEL_W-1:0]),
      .tap_o(tap)
   );

   // Outputs registered so the analog switches never glitch
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= '0; // [R7]
         tap_ff <= 32'h0000_0000;
         pin_ff <= 1'b0;
         src_supply_ff <= 1'b0;
         src_extpin_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         tap_ff <= tap; // [R5] [R6]
         // Pin needs converter on, its own enable and the external gate
         pin_ff <= nxt_ctrl.converter_on & nxt_ctrl.pin_output_on // [R1]
            & gate_sync_ff; // [R2]
         src_supply_ff <= nxt_ctrl.converter_on &
            (nxt_ctrl.upper_source_select == drc_pkg::SRC_SUPPLY); // [R3]
         src_extpin_ff <= nxt_ctrl.converter_on &
            (nxt_ctrl.upper_source_select == drc_pkg::SRC_EXTPIN); // [R3]
      end
   end

   assign ctrl_o = ctrl_ff;
   assign tap_o = tap_ff;
   assign analog_out_pin_o = pin_ff;
   assign src_supply_o = src_supply_ff;
   assign src_extpin_o = src_extpin_ff;
endmodule
`default_nettype wire

// File: tb/drc_asserts.sv
// Purpose: port checks for drc_top
// Assumes: outputs trail the registers by one edge
// Notes: gate path is checked only while held low
`default_nettype none
module drc_asserts (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic [31:0] tap_o,
   input wire logic [3:0] pstrb_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic fixed_ref_gate_i,
   input wire logic analog_out_pin_o,
   input wire logic src_supply_o,
   input wire logic src_extpin_o,
   input wire drc_pkg::drc_ctrl_t ctrl_o
);
   logic acc, wr;
   logic [15:0] w;
   // Completed access and accepted write
   assign acc = psel_i && penable_i && pready_o;
   assign wr = acc && pwrite_i && pstrb_i[0];
   // Write data delayed to when outputs show it
   always_ff @(posedge clk_i) w <= {w[7:0], pwdata_i[7:0]};
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_RST: assert property (!$past(rst_n_i) |-> ctrl_o == '0)
      else $error("reset value");
   AST_CFG: assert property (wr && paddr_i == 12'h000 |=>
      ##1 ctrl_o[8:5] == {w[15:13], w[10]}) else $error("config");
   AST_LVL: assert property (wr && paddr_i == 12'h004 |=>
      ##1 ctrl_o.level_code == w[12:8]) else $error("level");
   AST_TAP: assert property (ctrl_o.converter_on |->
      tap_o == 32'h1 << ctrl_o.level_code) else $error("tap");
   AST_SRC: assert property (ctrl_o.converter_on |->
      src_extpin_o == ctrl_o.upper_source_select
      && src_supply_o != src_extpin_o) else $error("source");
   AST_PIN: assert property (analog_out_pin_o |->
      ctrl_o.converter_on && ctrl_o.pin_output_on) else $error("pin");
   AST_GATE: assert property (!fixed_ref_gate_i [*4] |->
      !analog_out_pin_o) else $error("gate");
   AST_RD: assert property (acc && !pwrite_i |-> (prdata_o &
      (paddr_i[2] ? 32'hffff_ffe0 : 32'hffff_ff1b)) == '0)
      else $error("read bits");
   cover property (wr && paddr_i == 12'h004);
   cover property (analog_out_pin_o);
   cover property (acc && pslverr_o);
endmodule
bind drc_top drc_asserts u_drc_asserts (
   .clk_i(clk_i),
   .rst_n_i(rst_n_i),
   .psel_i(psel_i),
   .penable_i(penable_i),
   .pwrite_i(pwrite_i),
   .paddr_i(paddr_i),
   .pwdata_i(pwdata_i),
   .prdata_o(prdata_o),
   .tap_o(tap_o),
   .pstrb_i(pstrb_i),
   .pready_o(pready_o),
   .pslverr_o(pslverr_o),
   .fixed_ref_gate_i(fixed_ref_gate_i),
   .analog_out_pin_o(analog_out_pin_o),
   .src_supply_o(src_supply_o),
   .src_extpin_o(src_extpin_o),
   .ctrl_o(ctrl_o)
);
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench for drc_top
// Assumes: zero-wait APB, outputs settle one edge after a write
// Notes: gate needs extra edges for its synchroniser
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, gate = 0;
   logic [11:0] pa = '0;
   logic [31:0] pwd = '0, prd, tap, r;
   logic rdy, err, pin, sup, ext, e;
   logic [3:0] ps = 4'h1;
   drc_pkg::drc_ctrl_t ctrl;
   int n_fail = 0, n_tests = 0, cyc = 0;
   drc_top u_drc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
      .pstrb_i(ps), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
      .fixed_ref_gate_i(gate), .ctrl_o(ctrl), .tap_o(tap),
      .analog_out_pin_o(pin), .src_supply_o(sup), .src_extpin_o(ext));
   // 25 MHz clock
   initial forever #20 clk_i = ~clk_i;
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         n_fail++;
         $display("mismatch %0t got %h exp %h", $time, g, x);
      end
   endtask
   task test_done;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Setup, then access held until ready is seen at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
      @(posedge clk_i);
      pen <= 1;
      do @(posedge clk_i); while (rdy !== 1'b1);
      r = prd;
      e = err;
      {psel, pen} <= 2'b00;
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task t_cfg;
      apb(0, 12'h000, 0);
      chk(r, 0);
      apb(1, 12'h000, 32'hffff_ffff);
      apb(0, 12'h000, 0);
      chk(r, 32'he4);
      chk(32'(ctrl), 32'h1e0);
      chk(32'({sup, ext}), 32'h1);
      apb(1, 12'h000, 32'h80);
      wt(2);
      chk(32'({sup, ext}), 32'h2);
      $display("config done");
   endtask
   task t_lvl;
      for (int i = 0; i < 32; i++) begin
         apb(1, 12'h004, 32'he0 | 32'(i));
         apb(0, 12'h004, 0);
         chk(r, 32'(i));
         chk(tap, 32'h1 << i);
      end
      $display("level done");
   endtask
   task t_pin;
      apb(1, 12'h000, 32'ha0);
      wt(4);
      chk(32'(pin), 0);
      @(posedge clk_i) gate <= 1;
      wt(4);
      chk(32'(pin), 1);
      apb(1, 12'h000, 32'h80);
      wt(2);
      chk(32'(pin), 0);
      $display("pin done");
   endtask
   task t_err;
      apb(1, 12'h008, 32'hff);
      chk(32'(e), 1);
      apb(0, 12'h000, 0);
      chk(r, 32'h80);
      rst_n_i <= 0;
      @(posedge clk_i);
      rst_n_i <= 1;
      wt(1);
      chk(32'(ctrl), 0);
      chk(tap, 0);
      // Write with lane 0 off must leave the level untouched
      @(posedge clk_i) ps <= 4'h0;
      apb(1, 12'h004, 32'h1f);
      ps <= 4'h1;
      apb(0, 12'h004, 0);
      chk(r, 0);
      $display("error done");
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1;
      t_cfg;
      t_lvl;
      t_pin;
      t_err;
      test_done;
   end
   // Watchdog against a hung handshake
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         test_done;
      end
   end
endmodule
`default_nettype wire
